// File: ebra_pkg.sv
// package for the external bus retry, halt and arbitration block
package ebra_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int FC_W   = 3;
  localparam int SIZE_W = 2;
  localparam int CLK_MHZ = 40;
  localparam int SYNC_CYCLES = 2;
  localparam int GRANT_DELAY = 2;
  localparam logic [1:0] SHOW_OFF       = 2'h0;
  localparam logic [1:0] SHOW_STALL_ENC = 2'h3;
  localparam logic [1:0] SIZE_BYTE      = 2'h1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [FC_W-1:0]   fc;
    logic [SIZE_W-1:0] size;
    logic              rd;
    logic [DATA_W-1:0] wdata;
    logic              locked;
  } ebra_cyc_t;

  typedef enum logic [2:0] {
    BS_IDLE  = 3'b000,
    BS_RUN   = 3'b001,
    BS_WAIT  = 3'b011,
    BS_SYNC  = 3'b010,
    BS_HALT  = 3'b110
  } ebra_bus_st_t;

  typedef enum logic [1:0] {
    AR_OWN   = 2'b00,
    AR_GRANT = 2'b01,
    AR_EXT   = 2'b11,
    AR_RELS  = 2'b10
  } ebra_arb_st_t;
endpackage

// File: ebra_arbiter.sv
// external bus retry, halt and arbitration logic
`timescale 1ns/1ps
module ebra_arbiter
  import ebra_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // core request side
  input  wire logic              cyc_req,
  input  wire ebra_cyc_t         cyc_in,
  output logic                   cyc_done,
  output logic                   cyc_bus_error_in,
  output logic [DATA_W-1:0]      cyc_rdata,
  output logic                   operand_end,
  output logic                   core_reset,
  output logic                   irq_block,
  // internal cycle for show cycles
  input  wire logic              int_cyc,
  input  wire ebra_cyc_t         int_in,
  input  wire logic [DATA_W-1:0] int_data,
  input  wire logic              int_ext_target,
  input  wire logic [1:0]        show_enable_field,
  output logic                   int_stall,
  // configuration and status
  input  wire logic              double_fault,
  output logic                   slave_mode,
  // external termination and arbitration pins
  input  wire logic              transfer_ack_n,
  input  wire logic              bus_error_in_n,
  input  wire logic              halt_line_n,
  input  wire logic              bus_request_n,
  input  wire logic              grant_ack_n,
  input  wire logic              factory_test_strap,
  input  wire logic [DATA_W-1:0] data_in,
  output logic                   bus_grant_n,
  // external bus outputs; enables low while driving
  output logic                   address_strobe_n,
  output logic                   data_strobe_n,
  output logic                   locked_cycle_n,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [FC_W-1:0]        fc_out,
  output logic [SIZE_W-1:0]      size_lines,
  output logic                   rd_wr_out,
  output logic                   ctl_oe_n,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n
);

  logic rst_s1_q, rst_s2_q, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // pin synchronisers, two flops each; cleared by the raw reset so that
  // the strap has passed both flops when the engine leaves reset
  logic [5:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
    end else begin
      pin_s1_q <= {factory_test_strap, transfer_ack_n, bus_error_in_n,
                   halt_line_n, bus_request_n, grant_ack_n};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic strap_s, ack, bus_error_in, halt, breq, gack;
  assign strap_s = pin_s2_q[5];
  assign ack     = ~pin_s2_q[4];
  assign bus_error_in    = ~pin_s2_q[3];
  assign halt    = ~pin_s2_q[2];
  assign breq    = ~pin_s2_q[1];
  assign gack    = ~pin_s2_q[0];

  // data sampled with the acknowledge; same synchroniser depth
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // bus cycle engine state
  ebra_bus_st_t bst_q, bst_d;
  ebra_cyc_t    cur_q, cur_d;
  logic [1:0]   sync_q, sync_d;
  logic         slave_q, slave_d, strap_done_q, strap_done_d;
  logic         done_d, done_q, bus_error_in_d, bus_error_in_q, core_rst_q, core_rst_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic         own_bus, grant_pend;
  logic         retry_ev, bus_error_in_only;

  assign retry_ev  = bus_error_in && halt;
  assign bus_error_in_only = bus_error_in && !halt;

  always_comb begin
    bst_d = bst_q;
    cur_d = cur_q;
    sync_d = sync_q;
    done_d = 1'b0;
    bus_error_in_d = 1'b0;
    rdata_d = rdata_q;
    slave_d = slave_q;
    strap_done_d = 1'b1;
    core_rst_d = 1'b0;
    if (!strap_done_q) begin
      slave_d = ~strap_s;
    end
    case (bst_q)
      BS_IDLE: begin
        // rule 8: halt stalls only the external start
        if (cyc_req && own_bus && !halt && !bus_error_in && !grant_pend) begin
          cur_d = cyc_in;
          bst_d = BS_RUN;
        end
      end
      BS_RUN: begin
        // rule 1: retry terminates cycle, strobes go inactive
        if (retry_ev) begin
          bst_d = BS_WAIT;
        end else if (bus_error_in_only && !(breq && cur_q.locked)) begin
          bus_error_in_d = 1'b1;
          bst_d = BS_HALT;
        end else if (bus_error_in_only) begin
          bst_d = BS_WAIT;
        end else if (ack) begin
          done_d = 1'b1;
          rdata_d = din_s2_q;
          bst_d = BS_HALT;
        end
      end
      BS_WAIT: begin
        // rule 2: wait for both lines released and the bus owned
        if (!bus_error_in && !halt && own_bus && !grant_pend) begin
          bst_d = BS_SYNC;
          sync_d = 2'h0;
        end
      end
      BS_SYNC: begin
        // rule 23: two cycle synchronisation delay
        if (bus_error_in || halt) begin
          bst_d = BS_WAIT;
        end else if (sync_q == 2'(SYNC_CYCLES - 1)) begin
          bst_d = BS_RUN;
        end else begin
          sync_d = sync_q + 2'h1;
        end
      end
      BS_HALT: begin
        if (!ack && !bus_error_in) begin
          bst_d = BS_IDLE;
        end
      end
      default: bst_d = BS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bst_q <= BS_IDLE;
      cur_q <= '0;
      sync_q <= 2'h0;
      done_q <= 1'b0;
      bus_error_in_q <= 1'b0;
      rdata_q <= '0;
      slave_q <= 1'b0;
      strap_done_q <= 1'b0;
      // core held in reset until the synchronised release
      core_rst_q <= 1'b1;
    end else begin
      bst_q <= bst_d;
      cur_q <= cur_d;
      sync_q <= sync_d;
      done_q <= done_d;
      bus_error_in_q <= bus_error_in_d;
      rdata_q <= rdata_d;
      slave_q <= slave_d;
      strap_done_q <= strap_done_d;
      core_rst_q <= core_rst_d;
    end
  end

  logic in_cycle;
  assign in_cycle = (bst_q == BS_RUN);
  // rule 14: operand boundary is when no cycle or retry is pending
  assign operand_end = (bst_q == BS_IDLE) || (bst_q == BS_HALT);
  // lock follows the pin, so a finished locked part no longer blocks the grant
  logic lock_act;
  assign lock_act = cur_q.locked && !operand_end;

  // arbiter
  ebra_arb_st_t ast_q, ast_d;
  logic [1:0]   adly_q, adly_d;
  logic         grant_q, grant_d;
  logic         grant_neg_q;

  always_comb begin
    ast_d = ast_q;
    adly_d = adly_q;
    grant_d = grant_q;
    case (ast_q)
      AR_OWN: begin
        // rule 17: state 0 held while request and acknowledge negated
        // requests accepted at an operand boundary or retry wait when unlocked, or in a wait on bus error alone
        if (breq && (operand_end || bst_q == BS_WAIT) && !lock_act) begin
          ast_d = AR_GRANT;
          grant_d = 1'b1;
        end else if (breq && bst_q == BS_WAIT && bus_error_in && !halt) begin
          ast_d = AR_GRANT;
          grant_d = 1'b1;
        end
      end
      AR_GRANT: begin
        // rule 15: master acks only after grant with ack inactive
        if (gack) begin
          ast_d = AR_EXT;
          adly_d = 2'h0;
        end else if (!breq) begin
          ast_d = AR_OWN;
          grant_d = 1'b0;
        end
      end
      AR_EXT: begin
        // drop, then regrant pending
        // the spare count code marks a grant already dropped, so the grant then follows the request
        if (adly_q < 2'(GRANT_DELAY)) begin
          adly_d = adly_q + 2'h1;
        end else if (adly_q == 2'(GRANT_DELAY)) begin
          adly_d = 2'h3;
          grant_d = 1'b0;
        end else begin
          grant_d = breq;
        end
        if (!gack) begin
          ast_d = grant_d ? AR_GRANT : AR_RELS;
        end
      end
      AR_RELS: begin
        ast_d = AR_OWN;
        grant_d = 1'b0;
      end
      default: begin
        ast_d = AR_OWN;
        grant_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ast_q <= AR_OWN;
      adly_q <= 2'h0;
      grant_q <= 1'b0;
    end else begin
      ast_q <= ast_d;
      adly_q <= adly_d;
      grant_q <= grant_d;
    end
  end

  // rule 17: grant pin changes on the falling edge after the state
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_neg_q <= 1'b0;
    end else begin
      grant_neg_q <= grant_q;
    end
  end

  assign own_bus    = (ast_q == AR_OWN);
  assign grant_pend = breq && !lock_act && (ast_q == AR_OWN);

  // show cycles
  logic show_on, show_act, show_byte_ext;
  // rule 19: field off means no strobes and floated data
  assign show_on  = (show_enable_field != SHOW_OFF);
  assign show_act = int_cyc && own_bus && !in_cycle;
  assign int_stall = (show_enable_field == SHOW_STALL_ENC) && !own_bus;
  assign show_byte_ext = int_ext_target && !int_in.rd && int_in.size == SIZE_BYTE;

  // registered pin outputs
  logic as_q, ds_q, lock_q, ctl_oe_q, doe_q;
  logic [DATA_W-1:0] dout_q;
  ebra_cyc_t pin_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      as_q <= 1'b1;
      ds_q <= 1'b1;
      lock_q <= 1'b1;
      ctl_oe_q <= 1'b1;
      doe_q <= 1'b1;
      dout_q <= '0;
      pin_q <= '0;
    end else begin
      // rule 1: address strobe high outside an active cycle; data strobe also goes low for show cycles when the show field is not off
      as_q <= ~in_cycle;
      ds_q <= ~(in_cycle || (show_act && show_on));
      // rule 5: lock held through every retry state
      lock_q <= ~(cur_q.locked && bst_q != BS_IDLE && bst_q != BS_HALT);
      // rule 11: float when another master owns bus, restore after
      ctl_oe_q <= ~own_bus;
      doe_q <= ~((in_cycle && !cur_q.rd) || (show_act && show_on));
      if (in_cycle) begin
        pin_q <= cur_q;
        dout_q <= cur_q.wdata;
      end else if (show_act) begin
        pin_q <= int_in;
        dout_q <= show_byte_ext ? {int_data[7:0], int_data[7:0]} : int_data;
      end
    end
  end

  assign address_strobe_n = as_q;
  assign data_strobe_n    = ds_q;
  assign locked_cycle_n   = lock_q;
  assign addr_out         = pin_q.addr;
  assign fc_out           = pin_q.fc;
  assign size_lines       = pin_q.size;
  assign rd_wr_out        = pin_q.rd;
  assign ctl_oe_n         = ctl_oe_q;
  assign data_out         = dout_q;
  assign data_oe_n        = doe_q;
  assign bus_grant_n      = ~grant_neg_q;
  assign cyc_done         = done_q;
  assign cyc_bus_error_in         = bus_error_in_q;
  assign cyc_rdata        = rdata_q;
  assign slave_mode       = slave_q;
  assign core_reset       = core_rst_q;
  // rule 11: interrupts blocked while halted
  assign irq_block        = halt || double_fault;

  // rule 1: no strobe during a retry wait
  a_retry_strobes: assert property (@(posedge clk) disable iff (!rst_n)
    (bst_q == BS_WAIT) |=> address_strobe_n)
    else $error("strobe active during retry wait");
  // rule 23: rerun two cycles after sync start
  a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
    (bst_q == BS_WAIT && bst_d == BS_SYNC) ##1 (!bus_error_in && !halt) [*2] |=> bst_q == BS_RUN)
    else $error("retry delay wrong");
  // rule 2: rerun uses the same cycle fields
  a_rerun_same: assert property (@(posedge clk) disable iff (!rst_n)
    (bst_q == BS_SYNC && bst_d == BS_RUN) |=> $stable(cur_q))
    else $error("rerun cycle changed");
  // rule 14: no grant while locked; a bus error alone in a locked cycle still lets the grant through
  a_no_lock_grant: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(grant_q) |-> $past(!lock_act || (bus_error_in && !halt) || ast_q != AR_OWN))
    else $error("grant during locked cycle");
  // rule 17: idle state holds with no request or ack
  a_arb_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (ast_q == AR_OWN && !breq && !gack) |=> ast_q == AR_OWN && !grant_q)
    else $error("arbiter left state 0");
  // rule 19: no address strobe for show cycles
  a_show_no_as: assert property (@(posedge clk) disable iff (!rst_n)
    (show_act && bst_q == BS_IDLE) |=> address_strobe_n)
    else $error("strobe on show cycle");
  // rule 8: halt blocks a new external start
  a_halt_stall: assert property (@(posedge clk) disable iff (!rst_n)
    (bst_q == BS_IDLE && halt) |=> bst_q != BS_RUN)
    else $error("cycle started under halt");
  // rule 11: outputs float while foreign master owns bus
  a_float_ext: assert property (@(posedge clk) disable iff (!rst_n)
    (ast_q == AR_EXT) |=> ctl_oe_n)
    else $error("outputs driven under foreign master");

endmodule // ebra_arbiter

// File: ebra_partner.sv
// partner model: bus termination logic and one external bus master
`timescale 1ns/1ps
module ebra_partner
  import ebra_pkg::*;
(
  // bench commands
  input  wire logic              clk,
  input  wire logic              fault_arm,
  input  wire logic [1:0]        fault_kind,
  input  wire logic              halt_req,
  input  wire logic              bus_want,
  input  wire logic [DATA_W-1:0] rd_value,
  // device pins seen
  input  wire logic              address_strobe_n,
  input  wire logic              bus_grant_n,
  // pins driven, pulled up when released
  output logic                   transfer_ack_n = 1'b1,
  output logic                   bus_error_in_n = 1'b1,
  output logic                   halt_line_n,
  output logic                   bus_request_n  = 1'b1,
  output logic                   grant_ack_n    = 1'b1,
  output logic [DATA_W-1:0]      data_in        = 16'hFFFF
);
  logic armed     = 1'b0;
  logic busy      = 1'b0;
  logic held_halt = 1'b0;
  logic served    = 1'b0;
  int   hold      = 0;
  int   own       = 0;

  assign halt_line_n = !(halt_req || held_halt);

  // termination: ack, or an armed fault once; kind 1 adds halt, kind 2 is error alone
  always @(posedge clk) begin
    if (fault_arm) armed <= 1'b1;
    if (address_strobe_n === 1'b0 && !busy) begin
      busy <= 1'b1;
      if (armed) begin
        // error without halt when only a bus error is wanted
        armed <= 1'b0;
        bus_error_in_n <= 1'b0;
        held_halt <= (fault_kind == 2'h1);
        hold <= 6;
      end else begin
        transfer_ack_n <= 1'b0;
        data_in <= rd_value;
      end
    end else if (busy && address_strobe_n === 1'b1) begin
      // error lines dropped well before the rerun reaches its data phase
      hold <= hold - 1;
      if (hold <= 1) begin
        busy <= 1'b0;
        transfer_ack_n <= 1'b1;
        bus_error_in_n <= 1'b1;
        held_halt <= 1'b0;
        data_in <= 16'hFFFF;
      end
    end
  end

  // external master: request, take on grant, hold for a while, release
  always @(posedge clk) begin
    if (!bus_want) served <= 1'b0;
    if (bus_want && !served && grant_ack_n) bus_request_n <= 1'b0;
    // take the bus only on grant with no other master active
    if (!bus_request_n && bus_grant_n === 1'b0 && grant_ack_n) begin
      grant_ack_n <= 1'b0;
      bus_request_n <= 1'b1;
      served <= 1'b1;
      own <= 12;
    end
    // acknowledge held for the whole tenure
    if (!grant_ack_n) begin
      own <= own - 1;
      if (own <= 1) grant_ack_n <= 1'b1;
    end
  end
endmodule // ebra_partner

// File: ext_bus_retry_halt_arbiter_test.sv
// self-checking bench for the retry, halt and arbitration block
`timescale 1ns/1ps
module ext_bus_retry_halt_arbiter_test
  import ebra_pkg::*;
();
  logic              clk = 1'b0, nrst = 1'b0, cyc_req = 1'b0, int_cyc = 1'b0;
  logic              int_ext_target = 1'b1, fault_arm = 1'b0, halt_req = 1'b0, bus_want = 1'b0;
  logic              strap_in = 1'b1, double_fault = 1'b0;
  ebra_cyc_t         cyc_in = '0, int_in = '0, cur = '0;
  logic [DATA_W-1:0] int_data = '0, rd_value = '0, cyc_rdata, data_out, data_in;
  logic [1:0]        show_enable_field = 2'h0, fault_kind = 2'h0;
  logic              cyc_done, cyc_bus_error_in, operand_end, core_reset, irq_block, int_stall;
  logic              slave_mode, transfer_ack_n, bus_error_in_n, halt_line_n, bus_request_n;
  logic              grant_ack_n, bus_grant_n, address_strobe_n, data_strobe_n, locked_cycle_n;
  logic              rd_wr_out, ctl_oe_n, data_oe_n, as_prev = 1'b1, ds_prev = 1'b1;
  logic [ADDR_W-1:0] addr_out;
  logic [FC_W-1:0]   fc_out;
  logic [SIZE_W-1:0] size_lines;
  int                err_total = 0, check_count = 0, seed = 13, starts = 0;
  int                t_now = 0, t_prev = 0, t_last = 0;

  always #12.5 clk = ~clk;

  ebra_arbiter dut_u (.clk, .nrst, .cyc_req, .cyc_in, .cyc_done, .cyc_bus_error_in, .cyc_rdata,
    .operand_end, .core_reset, .irq_block, .int_cyc, .int_in, .int_data, .int_ext_target,
    .show_enable_field, .int_stall, .double_fault, .slave_mode, .transfer_ack_n,
    .bus_error_in_n, .halt_line_n, .bus_request_n, .grant_ack_n, .factory_test_strap(strap_in),
    .data_in, .bus_grant_n, .address_strobe_n, .data_strobe_n, .locked_cycle_n, .addr_out,
    .fc_out, .size_lines, .rd_wr_out, .ctl_oe_n, .data_out, .data_oe_n);

  ebra_partner part_u (.clk, .fault_arm, .fault_kind, .halt_req, .bus_want, .rd_value,
    .address_strobe_n, .bus_grant_n, .transfer_ack_n, .bus_error_in_n, .halt_line_n,
    .bus_request_n, .grant_ack_n, .data_in);

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // one core cycle, held until done or error; the model keeps the fields in cur
  task automatic run_cyc(input logic rd, input logic lock, output logic bus_error_in);
    logic [63:0] r;
    int          i;
    r = {$random(seed), $random(seed)};
    cur = r[$bits(ebra_cyc_t)-1:0];
    cur.rd = rd;
    cur.locked = lock;
    rd_value = DATA_W'($random(seed));
    step();
    cyc_in = cur;
    cyc_req = 1'b1;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (cyc_done === 1'b1 || cyc_bus_error_in === 1'b1) break;
    end
    if (i == 300) begin
      err_total++;
      stop_test();
    end
    bus_error_in = cyc_bus_error_in;
    if (rd && !bus_error_in) chk("rdata", rd_value, cyc_rdata); // data returned
    step();
    cyc_req = 1'b0;
  endtask

  // strobe monitor: every strobe, first or rerun, must show the modelled fields
  always @(negedge clk) begin
    t_now++;
    if (address_strobe_n === 1'b0 && as_prev === 1'b1) begin
      starts++;
      t_prev = t_last;
      t_last = t_now;
      chk("addr", cur.addr, addr_out); // same address
      chk("fc", cur.fc, fc_out); // same function code
      chk("rw", cur.rd, rd_wr_out); // same direction
    end
    if (data_strobe_n === 1'b0 && ds_prev === 1'b1 && !cur.rd && !int_cyc)
      chk("wdata", cur.wdata, data_out); // same write data
    as_prev = address_strobe_n;
    ds_prev = data_strobe_n;
    if (locked_cycle_n === 1'b0) chk("grant in lock", 1, bus_grant_n); // no grant
  end

  initial begin
    logic b;
    int   i, k, ds_n, shown;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) step();
    chk("grant idle", 1, bus_grant_n); // idle arbiter
    chk("strobes idle", 2'h3, {address_strobe_n, data_strobe_n}); // no strobes
    chk("slave", 0, slave_mode); // strap left high
    chk("core reset", 0, core_reset); // core released
    for (k = 0; k < 8; k++) begin
      run_cyc(k[0], 1'b0, b);
      chk("bus_error_in", 0, b); // acknowledged cycle
    end
    chk("starts", 8, starts); // one strobe a cycle
    chk("operand end", 1, operand_end); // boundary reached
    // kind 1 is a locked retry, kind 2 a plain error
    for (k = 1; k < 3; k++) begin
      fault_kind = k[1:0];
      fault_arm = 1'b1;
      i = starts;
      step();
      fault_arm = 1'b0;
      run_cyc(1'b0, k == 1, b);
      chk("retry bus_error_in", k == 2, b); // halt turns error into retry
      chk("strobes", (k == 1) ? 2 : 1, starts - i); // rerun once
      if (k == 1) chk("gap", 1, t_last - t_prev >= 6 + SYNC_CYCLES); // waits
    end
    // halt during a write, then a stalled request released by one step
    fork
      run_cyc(1'b0, 1'b0, b);
      begin
        // halt raised once the write is on the bus, not while an old cycle drains
        for (i = 0; i < 100 && address_strobe_n !== 1'b0; i++) step();
        halt_req = 1'b1;
      end
    join
    repeat (4) @(negedge clk);
    chk("held addr", cur.addr, addr_out); // outputs kept
    chk("data float", 1, data_oe_n); // data released
    chk("irq", 1, irq_block); // no interrupts halted
    i = starts;
    fork
      run_cyc(1'b0, 1'b0, b);
      begin
        repeat (20) step();
        chk("halted", i, starts); // no external cycle
        halt_req = 1'b0;
      end
    join
    chk("stepped", i + 1, starts); // release lets one run
    // arbitration running and halted
    // pass 2 asks again after a double fault; the stall encoding is set throughout
    for (k = 0; k < 3; k++) begin
      halt_req = (k == 1);
      double_fault = (k == 2);
      show_enable_field = SHOW_STALL_ENC;
      bus_want = 1'b1;
      for (i = 0; i < 100 && grant_ack_n !== 1'b0; i++) step();
      chk("granted", 0, grant_ack_n); // request accepted
      repeat (8) step();
      chk("ctl float", 1, ctl_oe_n); // device yields pins
      chk("grant off", 1, bus_grant_n); // grant drops after ack
      chk("int stall", 1, int_stall); // internals stalled
      for (i = 0; i < 100 && grant_ack_n !== 1'b1; i++) step();
      bus_want = 1'b0;
      repeat (8) step();
      if (k == 1) chk("restored", cur.addr, addr_out); // earlier values back
      chk("ctl back", 0, ctl_oe_n); // pins driven again
      chk("stall off", 0, int_stall); // stall ends
      chk("irq blocked", k != 0, irq_block); // no interrupts halted
      halt_req = 1'b0;
      double_fault = 1'b0;
    end
    // request arriving inside a locked cycle waits for its end
    fork
      run_cyc(1'b1, 1'b1, b);
      begin
        step();
        bus_want = 1'b1;
      end
    join
    for (i = 0; i < 100 && grant_ack_n !== 1'b0; i++) step();
    chk("lock grant", 0, grant_ack_n); // granted once unlocked
    repeat (40) step();
    bus_want = 1'b0;
    repeat (8) step();
    // show cycles off, on, and on with stall
    for (k = 0; k < 3; k++) begin
      show_enable_field = (k == 2) ? SHOW_STALL_ENC : k[1:0];
      int_in = ebra_cyc_t'({$random(seed), 15'h0});
      int_in.size = SIZE_BYTE;
      int_in.rd = 1'b0;
      int_data = DATA_W'($random(seed));
      int_cyc = 1'b1;
      i = starts;
      ds_n = 0;
      shown = 0;
      repeat (4) begin
        @(negedge clk);
        if (data_strobe_n === 1'b0) ds_n++;
        if (data_oe_n === 1'b0 && data_out === {int_data[7:0], int_data[7:0]}) shown++;
      end
      chk("show ds", k != 0, ds_n != 0); // data strobe shown
      chk("show data", k != 0, shown != 0); // byte on both halves
      chk("show as", i, starts); // no address strobe
      chk("int addr", int_in.addr, addr_out); // address visible
      chk("show size", SIZE_BYTE, size_lines); // size shown
      step();
      int_cyc = 1'b0;
      repeat (3) step();
    end
    // second reset in mid-run, strap pulled low this time
    strap_in = 1'b0;
    nrst = 1'b0;
    step();
    chk("core held", 1, core_reset); // core kept in reset
    chk("grant reset", 1, bus_grant_n); // arbiter back in state 0
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) step();
    chk("slave", 1, slave_mode); // strap low selects slave
    chk("core reset", 0, core_reset); // core released
    stop_test();
  end
endmodule // ext_bus_retry_halt_arbiter_test
